// [inc/osc_req_pkg.sv]
`default_nettype none
package osc_req_pkg;
	// Bus widths
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned STRB_W = 4;
	localparam int unsigned REQ_W  = 8;
	localparam int unsigned OSC_N  = 5;
	localparam int unsigned EXT_CFG_W = 3;
	localparam int unsigned FRQ_SEL_W = 4;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] REQ_REG_OFS  = 4'h0;
	localparam logic [ADDR_W-1:0] STAT_REG_OFS = 4'h4;

	// Request register layout and reset
	localparam logic [REQ_W-1:0] REQ_IMPL_MASK = 8'hdc;
	localparam logic [REQ_W-1:0] REQ_RESET     = 8'h00;
	localparam int unsigned EXT_BIT  = 7;
	localparam int unsigned FAST_BIT = 6;
	localparam int unsigned SLOW_BIT = 4;
	localparam int unsigned SEC_BIT  = 3;
	localparam int unsigned CONV_BIT = 2;

	// Oscillator vector indices
	localparam int unsigned OSC_CONV = 0;
	localparam int unsigned OSC_SEC  = 1;
	localparam int unsigned OSC_SLOW = 2;
	localparam int unsigned OSC_FAST = 3;
	localparam int unsigned OSC_EXT  = 4;

	// Register bit that carries each oscillator index
	localparam int unsigned REQ_BIT_OF_OSC [OSC_N] = '{CONV_BIT, SEC_BIT, SLOW_BIT,
		FAST_BIT, EXT_BIT};

	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Address is one of the mapped registers
	function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
		addr_mapped = (a == REQ_REG_OFS) || (a == STAT_REG_OFS);
	endfunction
endpackage
`default_nettype wire

// [rtl/osc_enable_merge.sv]
`timescale 1ns/1ns
`default_nettype none
module osc_enable_merge (
	input  wire logic                              aclk,
	input  wire logic                              aresetn,
	input  wire logic                              clk_en,
	input  wire logic [osc_req_pkg::OSC_N-1:0]     force_on,
	input  wire logic [osc_req_pkg::OSC_N-1:0]     module_req,
	input  wire logic [osc_req_pkg::EXT_CFG_W-1:0] ext_cfg,
	input  wire logic [osc_req_pkg::FRQ_SEL_W-1:0] frq_sel,
	output var  logic [osc_req_pkg::OSC_N-1:0]     run_en,
	output var  logic [osc_req_pkg::EXT_CFG_W-1:0] ext_mode,
	output var  logic [osc_req_pkg::FRQ_SEL_W-1:0] fast_frq
);
	import osc_req_pkg::*;

	// One registered enable per oscillator
	genvar gi;
	generate
		for (gi = 0; gi < OSC_N; gi++) begin : g_osc
			// Enable is software force or any module request
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					run_en[gi] <= 1'b0;
				end else if (clk_en) begin
					run_en[gi] <= force_on[gi] | module_req[gi];
				end
			end
		end
	endgenerate

	// Operating settings follow their selection fields
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_mode <= '0;
			fast_frq <= '0;
		end else if (clk_en) begin
			ext_mode <= ext_cfg;
			fast_frq <= frq_sel;
		end
	end
endmodule // osc_enable_merge
`default_nettype wire

// [rtl/oscillator_manual_enable.sv]
// Behaviour
// - Bit 7 forces external oscillator, configured mode
// - Bit 6 forces fast oscillator, selected frequency
// - Bit 4 forces slow 31 kHz oscillator
// - Bit 3 forces secondary oscillator
// - Bit 2 forces 600 kHz converter oscillator
// - Enable is OR of force and requests
// - Bits 5, 1, 0 read zero
`timescale 1ns/1ns
`default_nettype none
module oscillator_manual_enable (
	input  wire logic                              aclk,
	input  wire logic                              aresetn,
	input  wire logic                              clk_en,
	input  wire logic [osc_req_pkg::ADDR_W-1:0]    awaddr,
	input  wire logic                              awvalid,
	output var  logic                              awready,
	input  wire logic [osc_req_pkg::DATA_W-1:0]    wdata,
	input  wire logic [osc_req_pkg::STRB_W-1:0]    wstrb,
	input  wire logic                              wvalid,
	output var  logic                              wready,
	output var  logic [1:0]                        bresp,
	output var  logic                              bvalid,
	input  wire logic                              bready,
	input  wire logic [osc_req_pkg::ADDR_W-1:0]    araddr,
	input  wire logic                              arvalid,
	output var  logic                              arready,
	output var  logic [osc_req_pkg::DATA_W-1:0]    rdata,
	output var  logic [1:0]                        rresp,
	output var  logic                              rvalid,
	input  wire logic                              rready,
	input  wire logic [osc_req_pkg::OSC_N-1:0]     module_osc_request,
	input  wire logic [osc_req_pkg::EXT_CFG_W-1:0] external_osc_config_field,
	input  wire logic [osc_req_pkg::FRQ_SEL_W-1:0] fast_osc_frequency_select,
	output var  logic [osc_req_pkg::OSC_N-1:0]     osc_run_enable,
	output var  logic [osc_req_pkg::EXT_CFG_W-1:0] external_osc_mode,
	output var  logic [osc_req_pkg::FRQ_SEL_W-1:0] fast_osc_freq
);
	import osc_req_pkg::*;

	logic [REQ_W-1:0]  req_q;       // Request register
	logic [REQ_W-1:0]  req_d;       // Next request value
	logic [OSC_N-1:0]  force_vec;   // Force bits per oscillator
	logic [REQ_W-1:0]  stat_vec;    // Enables in register layout
	logic              aw_hold_q;   // Write address captured
	logic [ADDR_W-1:0] aw_addr_q;   // Captured write address
	logic              w_hold_q;    // Write data captured
	logic [DATA_W-1:0] w_data_q;    // Captured write data
	logic [STRB_W-1:0] w_strb_q;    // Captured write strobes
	logic              bvalid_q;    // Write response pending
	logic [1:0]        bresp_q;     // Write response code
	logic              rvalid_q;    // Read response pending
	logic [DATA_W-1:0] rdata_q;     // Read data
	logic [1:0]        rresp_q;     // Read response code
	logic              aw_take;     // Address handshake
	logic              w_take;      // Data handshake
	logic              ar_take;     // Read address handshake
	logic              wr_fire;     // Both halves present
	logic [ADDR_W-1:0] wr_addr;     // Effective write address
	logic [DATA_W-1:0] wr_data;     // Effective write data
	logic [STRB_W-1:0] wr_strb;     // Effective write strobes
	logic              wr_req_hit;  // Write lands on request register
	logic [DATA_W-1:0] rd_mux;      // Selected read data

	// Bus handshakes, all frozen while clock enable is low
	assign awready = clk_en & ~aw_hold_q & ~bvalid_q;
	assign wready  = clk_en & ~w_hold_q & ~bvalid_q;
	assign arready = clk_en & ~rvalid_q;
	assign bvalid  = clk_en & bvalid_q;
	assign rvalid  = clk_en & rvalid_q;
	assign bresp   = bresp_q;
	assign rresp   = rresp_q;
	assign rdata   = rdata_q;
	assign aw_take = awvalid & awready;
	assign w_take  = wvalid & wready;
	assign ar_take = arvalid & arready;

	// Write path selects captured or live halves
	assign wr_addr    = aw_hold_q ? aw_addr_q : awaddr;
	assign wr_data    = w_hold_q ? w_data_q : wdata;
	assign wr_strb    = w_hold_q ? w_strb_q : wstrb;
	assign wr_fire    = (aw_hold_q | aw_take) & (w_hold_q | w_take);
	assign wr_req_hit = wr_fire & (wr_addr == REQ_REG_OFS) & wr_strb[0];

	// Only implemented bits store; others stay zero
	assign req_d = wr_req_hit ? (wr_data[REQ_W-1:0] & REQ_IMPL_MASK) : req_q;

	// Per-oscillator force bits and status in register layout
	genvar gi;
	generate
		for (gi = 0; gi < OSC_N; gi++) begin : g_map
			assign force_vec[gi] = req_q[REQ_BIT_OF_OSC[gi]];
			assign stat_vec[REQ_BIT_OF_OSC[gi]] = osc_run_enable[gi];
		end
	endgenerate

	// Unimplemented status bits tied low, picked out by the mask
	genvar gb;
	generate
		for (gb = 0; gb < REQ_W; gb++) begin : g_unimpl
			if (!REQ_IMPL_MASK[gb]) begin : g_zero
				assign stat_vec[gb] = 1'b0;
			end
		end
	endgenerate

	// Read data select; unmapped reads as zero
	assign rd_mux = (araddr == REQ_REG_OFS)  ? {{(DATA_W-REQ_W){1'b0}}, req_q} :
	                (araddr == STAT_REG_OFS) ? {{(DATA_W-REQ_W){1'b0}}, stat_vec} :
	                '0;

	// Request register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			req_q <= REQ_RESET;
		end else if (clk_en) begin
			req_q <= req_d;
		end
	end

	// Write channel capture and response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
			aw_addr_q <= '0;
			w_data_q  <= '0;
			w_strb_q  <= '0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
		end else if (clk_en) begin
			if (wr_fire) begin
				// Both halves here: answer next cycle
				aw_hold_q <= 1'b0;
				w_hold_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= addr_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
			end else begin
				// Hold whichever half came first
				if (aw_take) begin
					aw_hold_q <= 1'b1;
					aw_addr_q <= awaddr;
				end
				if (w_take) begin
					w_hold_q <= 1'b1;
					w_data_q <= wdata;
					w_strb_q <= wstrb;
				end
				if (bvalid_q && bready) begin
					bvalid_q <= 1'b0;
				end
			end
		end
	end

	// Read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= '0;
			rresp_q  <= RESP_OKAY;
		end else if (clk_en) begin
			if (ar_take) begin
				// Sample data at address acceptance
				rvalid_q <= 1'b1;
				rdata_q  <= rd_mux;
				rresp_q  <= addr_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
			end else if (rvalid_q && rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// Enable merge and operating settings
	osc_enable_merge u_merge (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.clk_en     (clk_en),
		.force_on   (force_vec),
		.module_req (module_osc_request),
		.ext_cfg    (external_osc_config_field),
		.frq_sel    (fast_osc_frequency_select),
		.run_en     (osc_run_enable),
		.ext_mode   (external_osc_mode),
		.fast_frq   (fast_osc_freq)
	);

	// External oscillator forced, in configured mode
	property p_ext_forced;
		@(posedge aclk) disable iff (!aresetn)
		aresetn && clk_en && req_q[EXT_BIT] |=>
			osc_run_enable[OSC_EXT] && external_osc_mode == $past(external_osc_config_field);
	endproperty
	a_ext_forced: assert property (p_ext_forced)
		else $error("external oscillator not forced on");

	// Fast oscillator forced, at selected frequency
	property p_fast_forced;
		@(posedge aclk) disable iff (!aresetn)
		aresetn && clk_en && req_q[FAST_BIT] |=>
			osc_run_enable[OSC_FAST] && fast_osc_freq == $past(fast_osc_frequency_select);
	endproperty
	a_fast_forced: assert property (p_fast_forced)
		else $error("fast oscillator not forced on");

	// Slow oscillator on by the second of two cycles of steady force
	property p_slow_forced;
		@(posedge aclk) disable iff (!aresetn)
		(aresetn && clk_en && req_q[SLOW_BIT])[*2] |-> osc_run_enable[OSC_SLOW];
	endproperty
	a_slow_forced: assert property (p_slow_forced)
		else $error("slow oscillator not forced on");

	// Secondary oscillator forced
	property p_sec_forced;
		@(posedge aclk) disable iff (!aresetn)
		aresetn && clk_en && req_q[SEC_BIT] |=> osc_run_enable[OSC_SEC];
	endproperty
	a_sec_forced: assert property (p_sec_forced)
		else $error("secondary oscillator not forced on");

	// Converter oscillator on two cycles after a write sets it
	property p_conv_write;
		@(posedge aclk) disable iff (!aresetn)
		aresetn && clk_en && wr_req_hit && wr_data[CONV_BIT] ##1 aresetn && clk_en
			|=> osc_run_enable[OSC_CONV];
	endproperty
	a_conv_write: assert property (p_conv_write)
		else $error("converter oscillator not forced after write");

	// Enable is exactly force or request
	property p_merge_or;
		@(posedge aclk) disable iff (!aresetn)
		aresetn && clk_en
			|=> osc_run_enable == ($past(force_vec) | $past(module_osc_request));
	endproperty
	a_merge_or: assert property (p_merge_or)
		else $error("oscillator enable is not force or request");

	// Unimplemented bits never read as one
	property p_unimpl_zero;
		@(posedge aclk) disable iff (!aresetn)
		rvalid_q |-> (rdata_q[REQ_W-1:0] & ~REQ_IMPL_MASK) == '0 && rdata_q[DATA_W-1:REQ_W] == '0;
	endproperty
	a_unimpl_zero: assert property (p_unimpl_zero)
		else $error("unimplemented bit read as one");

	// Reset clears every request bit
	property p_reset_clear;
		@(posedge aclk)
		!aresetn |=> req_q == REQ_RESET;
	endproperty
	a_reset_clear: assert property (p_reset_clear)
		else $error("request bits not cleared by reset");
endmodule // oscillator_manual_enable
`default_nettype wire

// [sim/oscillator_manual_enable_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module oscillator_manual_enable_tb_top;
	import osc_req_pkg::*;
	// Bench driven inputs
	logic                 aclk    = 1'b0;
	logic                 aresetn = 1'b0;
	logic                 clk_en  = 1'b1;
	logic [ADDR_W-1:0]    awaddr  = '0, araddr = '0;
	logic                 awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic                 arvalid = 1'b0, rready = 1'b0;
	logic [DATA_W-1:0]    wdata   = '0;
	logic [STRB_W-1:0]    wstrb   = '0;
	logic [OSC_N-1:0]     mreq    = '0;
	logic [EXT_CFG_W-1:0] cfg     = '0;
	logic [FRQ_SEL_W-1:0] frq     = '0;
	// Design outputs
	logic                 awready, wready, bvalid, arready, rvalid;
	logic [1:0]           bresp, rresp;
	logic [DATA_W-1:0]    rdata;
	logic [OSC_N-1:0]     run_en;
	logic [EXT_CFG_W-1:0] xmode;
	logic [FRQ_SEL_W-1:0] ffrq;
	// Expected answers, oldest first
	logic [33:0]          rd_q[$];
	logic [1:0]           wr_q[$];
	logic [7:0]           shadow  = 8'h00;
	logic [31:0]          rng     = 32'h251fcae9;
	int                   error_cnt = 0, tests_run = 0;

	// Free running clock
	always #25 aclk = ~aclk;

	oscillator_manual_enable uut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.module_osc_request(mreq), .external_osc_config_field(cfg),
		.fast_osc_frequency_select(frq), .osc_run_enable(run_en),
		.external_osc_mode(xmode), .fast_osc_freq(ffrq));

	// Random source
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	// Force vector from request bits
	function automatic logic [OSC_N-1:0] force_of(input logic [7:0] r);
		return {r[7], r[6], r[4], r[3], r[2]};
	endfunction
	// Status word from enables
	function automatic logic [7:0] stat_of(input logic [OSC_N-1:0] e);
		return {e[4], e[3], 1'b0, e[2], e[1], e[0], 2'b00};
	endfunction

	// Compare and count
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Verdict and end of run
	task automatic summarize();
		$display("compares=%0d mismatches=%0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Write cycle, both halves offered together
	task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] s,
		input logic [1:0] resp);
		wr_q.push_back(resp);
		if (resp == RESP_OKAY && a == 4'h0 && s[0]) shadow = d & 8'hdc;
		awaddr  <= a;
		awvalid <= 1'b1;
		wdata   <= {rng[31:8], d};
		wstrb   <= s;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		bready <= 1'b0;
		// Idle edge so a following call never re-drives bready in this step
		@(posedge aclk);
	endtask

	// Read cycle
	task automatic rd(input logic [3:0] a, input logic [33:0] exp);
		rd_q.push_back(exp);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		rready <= 1'b0;
		// Idle edge so a following call never re-drives rready in this step
		@(posedge aclk);
	endtask

	// Response monitor against the queued notes
	always @(posedge aclk) begin
		if (bvalid === 1'b1 && bready) chk(bresp, wr_q.pop_front());
		if (rvalid === 1'b1 && rready) chk({rresp, rdata}, rd_q.pop_front());
	end

	// Hang guard
	initial begin
		repeat (5000) @(posedge aclk);
		error_cnt++;
		summarize();
	end

	// Main sequence
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(REQ_REG_OFS, {RESP_OKAY, 32'h0});
		rd(STAT_REG_OFS, {RESP_OKAY, 32'h0});
		$display("test reset done");
		// Each bit alone, unimplemented ones included
		for (int i = 0; i < 8; i++) begin
			wr(REQ_REG_OFS, 8'h01 << i, 4'hf, RESP_OKAY);
			rd(REQ_REG_OFS, {RESP_OKAY, 24'h0, shadow});
			repeat (3) @(posedge aclk);
			chk(run_en, force_of(shadow));
		end
		$display("test single bits done");
		// Random forces and module requests merged
		for (int i = 0; i < 40; i++) begin
			rng = xs(rng);
			mreq <= rng[4:0];
			cfg  <= rng[7:5];
			frq  <= rng[11:8];
			wr(REQ_REG_OFS, rng[23:16], {3'b111, rng[24]}, RESP_OKAY);
			repeat (3) @(posedge aclk);
			chk(run_en, force_of(shadow) | mreq);
			chk({xmode, ffrq}, {cfg, frq});
			rd(STAT_REG_OFS, {RESP_OKAY, 24'h0, stat_of(force_of(shadow) | mreq)});
		end
		$display("test merge done");
		// Unmapped and read-only places leave the register alone
		wr(4'h8, 8'hff, 4'hf, RESP_SLVERR);
		wr(STAT_REG_OFS, 8'hff, 4'hf, RESP_OKAY);
		rd(4'hc, {RESP_SLVERR, 32'h0});
		rd(REQ_REG_OFS, {RESP_OKAY, 24'h0, shadow});
		$display("test refusals done");
		// Reset in mid-run clears all forces
		wr(REQ_REG_OFS, 8'hff, 4'hf, RESP_OKAY);
		aresetn <= 1'b0;
		mreq    <= '0;
		@(posedge aclk);
		aresetn <= 1'b1;
		shadow = 8'h00;
		repeat (2) @(posedge aclk);
		rd(REQ_REG_OFS, {RESP_OKAY, 32'h0});
		repeat (3) @(posedge aclk);
		chk(run_en, 5'h00);
		$display("test second reset done");
		// Clock enable low freezes the merged enables
		mreq   <= 5'h1f;
		clk_en <= 1'b0;
		repeat (3) @(posedge aclk);
		chk(run_en, 5'h00);
		clk_en <= 1'b1;
		repeat (2) @(posedge aclk);
		chk(run_en, 5'h1f);
		$display("test clock enable done");
		summarize();
	end
endmodule // oscillator_manual_enable_tb_top
`default_nettype wire
